// *** logic/dq_engine.sv ***
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
module dq_engine import dq_pkg::*; (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [DQ_AW-1:0] paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  output logic                  mem_req_o,
  output logic                  mem_we_o,
  output logic      [31:0]      mem_addr_o,
  output logic      [31:0]      mem_wdata_o,
  input  wire logic             mem_ack_i,
  input  wire logic [31:0]      mem_rdata_i,
  output logic                  job_valid_o,
  output logic                  job_tx_o,
  output logic      [2:0]       job_chan_o,
  output logic                  job_first_o,
  output logic                  job_last_o,
  output logic      [31:0]      job_addr_o,
  output logic      [15:0]      job_len_o,
  output logic      [15:0]      job_pkt_len_o,
  input  wire logic             job_done_i,
  input  wire logic [15:0]      job_moved_i,
  output logic                  irq_o
);
  // ===========================================================
  // Register access carrier and helpers
  dq_reg_if rif();

  dq_apb_slave u_apb (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .rif       (rif.bus)
  );

  // ===========================================================
  // Engine state
  typedef struct packed {
    dq_state_t               st;
    logic [DQ_NCH-1:0][31:0] head;
    logic [DQ_NCH-1:0][31:0] last;
    logic [3:0]              ch;
    logic [31:0]             cur;
    logic [31:0]             nxt;
    logic [31:0]             bptr;
    logic [31:0]             offlen;
    logic [31:0]             flags;
    logic [31:0]             first_addr;
    logic [31:0]             first_flags;
    logic [15:0]             moved;
    logic                    mem_req;
    logic                    mem_we;
    logic [31:0]             mem_addr;
    logic [31:0]             mem_wdata;
    logic                    job_valid;
    logic                    job_first;
    logic                    job_last;
    logic [31:0]             job_addr;
    logic [15:0]             job_len;
    logic [15:0]             job_pkt_len;
  } dq_core_t;

  dq_core_t   q;
  dq_core_t   n;
  logic       is_tx;
  logic [3:0] widx;
  logic [1:0] wrgn;

  dq_irq_unit u_irq (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .rif       (rif.irq),
    .last_i    (q.last),
    .irq_o     (irq_o)
  );

  assign is_tx = q.ch < DQ_RX_BASE;
  assign widx  = rif.addr[DQ_IDX_MSB:DQ_IDX_LSB];
  assign wrgn  = rif.addr[DQ_RGN_MSB:DQ_RGN_LSB];

  // ===========================================================
  // Head pointer reads
  // sixteen head pointers, transmit then receive
  assign rif.core_hit   = wrgn == DQ_RGN_HEAD;
  assign rif.core_rdata = q.head[widx];

  // ===========================================================
  // Descriptor walk
  always_comb begin
    logic found;
    logic first;
    logic [31:0] fl;
    found = 1'b0;
    first = 1'b0;
    fl    = 32'h0;
    n     = q;
    case (q.st)
      DQ_ST_IDLE: begin
        // Fixed priority, lowest channel first; long lists can starve higher ones
        for (int i = 0; i < DQ_NCH; i++) begin
          if (!found && q.head[i] != DQ_PTR_RST) begin
            found = 1'b1;
            n.ch  = 4'(i);
          end
        end
        if (found) begin
          n.cur      = q.head[n.ch];
          n.moved    = 16'h0;
          n.mem_req  = 1'b1;
          n.mem_we   = 1'b0;
          n.mem_addr = q.head[n.ch] + DQ_W_NEXT;
          n.st       = DQ_ST_NEXT;
        end
      end
      DQ_ST_NEXT: begin
        if (mem_ack_i) begin
          n.nxt      = mem_rdata_i;
          n.mem_addr = q.cur + DQ_W_BUF;
          n.st       = DQ_ST_BUF;
        end
      end
      DQ_ST_BUF: begin
        if (mem_ack_i) begin
          n.bptr     = mem_rdata_i;
          n.mem_addr = q.cur + DQ_W_LEN;
          n.st       = DQ_ST_LEN;
        end
      end
      DQ_ST_LEN: begin
        if (mem_ack_i) begin
          n.offlen   = mem_rdata_i;
          n.mem_addr = q.cur + DQ_W_FLAG;
          n.st       = DQ_ST_FLAG;
        end
      end
      DQ_ST_FLAG: begin
        if (mem_ack_i) begin
          n.mem_req = 1'b0;
          n.flags   = mem_rdata_i;
          first     = mem_rdata_i[DQ_F_FIRST];
          // ownership decided on first fragment only
          if (first && !mem_rdata_i[DQ_F_HOLD]) begin
            n.head[q.ch] = DQ_PTR_RST;
            n.st         = DQ_ST_IDLE;
          end else begin
            if (first) begin
              n.first_addr  = q.cur;
              n.first_flags = mem_rdata_i;
              n.moved       = 16'h0;
            end
            // buffer pointer is where the data lives
            n.job_addr = q.bptr;
            // skip leading offset in the first buffer of data-bearing packets
            if (is_tx && first) begin
              n.job_addr = q.bptr + {16'h0, q.offlen[DQ_HI_MSB:DQ_HI_LSB]};
            end
            // length is data count or capacity
            n.job_len     = q.offlen[DQ_LO_MSB:0];
            // packet length only on data-bearing first fragment
            n.job_pkt_len = (is_tx && first) ? mem_rdata_i[DQ_LO_MSB:0] : 16'h0;
            n.job_first   = first;
            n.job_last    = mem_rdata_i[DQ_F_LAST];
            n.job_valid   = 1'b1;
            n.st          = DQ_ST_JOB;
          end
        end
      end
      DQ_ST_JOB: begin
        if (job_done_i) begin
          n.job_valid = 1'b0;
          n.moved     = q.moved + job_moved_i;
          if (q.flags[DQ_F_LAST]) begin
            fl = q.flags;
            // mark list end when link is null
            if (q.nxt == DQ_PTR_RST) begin
              fl[DQ_F_HALT] = 1'b1;
            end
            // a single-descriptor packet is returned in one write
            if (q.cur == q.first_addr) begin
              fl[DQ_F_HOLD] = 1'b0;
              if (!is_tx) begin
                fl[DQ_LO_MSB:0] = q.moved + job_moved_i;
              end
            end
            n.mem_req   = 1'b1;
            n.mem_we    = 1'b1;
            n.mem_addr  = q.cur + DQ_W_FLAG;
            n.mem_wdata = fl;
            n.st        = DQ_ST_WEOP;
          end else if (q.nxt != DQ_PTR_RST) begin
            // stay on the channel for the next fragment
            n.cur      = q.nxt;
            n.mem_req  = 1'b1;
            n.mem_we   = 1'b0;
            n.mem_addr = q.nxt + DQ_W_NEXT;
            n.st       = DQ_ST_NEXT;
          end else begin
            // Broken packet with no last fragment: give up the channel
            n.head[q.ch] = DQ_PTR_RST;
            n.st         = DQ_ST_IDLE;
          end
        end
      end
      DQ_ST_WEOP: begin
        if (mem_ack_i) begin
          if (q.cur == q.first_addr) begin
            n.mem_req    = 1'b0;
            n.mem_we     = 1'b0;
            n.last[q.ch] = q.cur;
            // null link leaves the channel halted
            n.head[q.ch] = q.nxt;
            n.st         = DQ_ST_IDLE;
          end else begin
            fl            = q.first_flags;
            // release ownership on the first fragment
            fl[DQ_F_HOLD] = 1'b0;
            if (!is_tx) begin
              fl[DQ_LO_MSB:0] = q.moved;
            end
            n.mem_addr  = q.first_addr + DQ_W_FLAG;
            n.mem_wdata = fl;
            n.st        = DQ_ST_WSOP;
          end
        end
      end
      DQ_ST_WSOP: begin
        if (mem_ack_i) begin
          n.mem_req    = 1'b0;
          n.mem_we     = 1'b0;
          n.last[q.ch] = q.cur;
          // null link leaves the channel halted
          n.head[q.ch] = q.nxt;
          n.st         = DQ_ST_IDLE;
        end
      end
      default: begin
        n.st = DQ_ST_IDLE;
      end
    endcase
    // head write is taken only by an idle channel
    if (rif.wr && wrgn == DQ_RGN_HEAD && q.head[widx] == DQ_PTR_RST) begin
      n.head[widx] = rif.wdata;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      q      <= '0;
      q.st   <= DQ_ST_IDLE;
      q.head <= '0;
      q.last <= '0;
    end else begin
      q <= n;
    end
  end

  // ===========================================================
  // Outputs
  assign mem_req_o     = q.mem_req;
  assign mem_we_o      = q.mem_we;
  assign mem_addr_o    = q.mem_addr;
  assign mem_wdata_o   = q.mem_wdata;
  assign job_valid_o   = q.job_valid;
  assign job_tx_o      = is_tx;
  assign job_chan_o    = q.ch[2:0];
  assign job_first_o   = q.job_first;
  assign job_last_o    = q.job_last;
  assign job_addr_o    = q.job_addr;
  assign job_len_o     = q.job_len;
  assign job_pkt_len_o = q.job_pkt_len;
endmodule

// *** logic/dq_pkg.sv ***
package dq_pkg;
  // ===========================================================
  // Sizes
  localparam int          DQ_NCH      = 16;
  localparam int          DQ_NDIR     = 8;
  localparam logic [3:0]  DQ_RX_BASE  = 4'h8;
  localparam logic [31:0] DQ_PTR_RST  = 32'h0;
  localparam logic [15:0] DQ_EN_RST   = 16'h0;

  // ===========================================================
  // Register map, byte addresses on an 8-bit APB address
  localparam int          DQ_AW       = 8;
  localparam int          DQ_RGN_MSB  = 7;
  localparam int          DQ_RGN_LSB  = 6;
  localparam int          DQ_IDX_MSB  = 5;
  localparam int          DQ_IDX_LSB  = 2;
  localparam logic [1:0]  DQ_RGN_HEAD = 2'h0;
  localparam logic [1:0]  DQ_RGN_COMP = 2'h1;
  localparam logic [7:0]  DQ_TX_EN_SET = 8'h80;
  localparam logic [7:0]  DQ_TX_EN_CLR = 8'h84;
  localparam logic [7:0]  DQ_RX_EN_SET = 8'h88;
  localparam logic [7:0]  DQ_RX_EN_CLR = 8'h8c;
  localparam logic [7:0]  DQ_TX_RAW    = 8'h90;
  localparam logic [7:0]  DQ_RX_RAW    = 8'h94;

  // ===========================================================
  // Descriptor layout
  localparam logic [31:0] DQ_W_NEXT   = 32'h0;
  localparam logic [31:0] DQ_W_BUF    = 32'h4;
  localparam logic [31:0] DQ_W_LEN    = 32'h8;
  localparam logic [31:0] DQ_W_FLAG   = 32'hc;
  localparam int          DQ_HI_MSB   = 31;
  localparam int          DQ_HI_LSB   = 16;
  localparam int          DQ_LO_MSB   = 15;
  localparam int          DQ_F_FIRST  = 31;
  localparam int          DQ_F_LAST   = 30;
  localparam int          DQ_F_HOLD   = 29;
  localparam int          DQ_F_HALT   = 28;

  // ===========================================================
  // Engine states
  typedef enum logic [2:0] {
    DQ_ST_IDLE  = 3'h0,
    DQ_ST_NEXT  = 3'h1,
    DQ_ST_BUF   = 3'h3,
    DQ_ST_LEN   = 3'h2,
    DQ_ST_FLAG  = 3'h6,
    DQ_ST_JOB   = 3'h7,
    DQ_ST_WEOP  = 3'h5,
    DQ_ST_WSOP  = 3'h4
  } dq_state_t;
endpackage

// *** logic/dq_reg_if.sv ***
`timescale 1ns/10ps
interface dq_reg_if;
  import dq_pkg::*;
  logic             wr;
  logic [DQ_AW-1:0] addr;
  logic [31:0]      wdata;
  logic [31:0]      core_rdata;
  logic             core_hit;
  logic [31:0]      irq_rdata;
  logic             irq_hit;
  modport bus  (output wr, addr, wdata, input core_rdata, core_hit, irq_rdata, irq_hit);
  modport core (input wr, addr, wdata, output core_rdata, core_hit);
  modport irq  (input wr, addr, wdata, output irq_rdata, irq_hit);
endinterface

// *** logic/dq_apb_slave.sv ***
`timescale 1ns/10ps
module dq_apb_slave import dq_pkg::*; (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [DQ_AW-1:0] paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  dq_reg_if.bus                 rif
);
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        err;
  } dq_apb_t;

  dq_apb_t q;
  dq_apb_t n;

  // One wait state so read data leaves a flip-flop
  always_comb begin
    n = q;
    if (q.ack) begin
      n.ack = 1'b0;
    end else if (psel_i && penable_i) begin
      n.ack   = 1'b1;
      n.err   = !(rif.core_hit || rif.irq_hit);
      n.rdata = rif.core_hit ? rif.core_rdata : (rif.irq_hit ? rif.irq_rdata : 32'h0);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign rif.wr    = psel_i && penable_i && pwrite_i && q.ack;
  assign rif.addr  = paddr_i;
  assign rif.wdata = pwdata_i;
  assign prdata_o  = q.rdata;
  assign pready_o  = q.ack;
  assign pslverr_o = q.ack && q.err;
endmodule

// *** logic/dq_irq_unit.sv ***
`timescale 1ns/10ps
module dq_irq_unit import dq_pkg::*; (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  dq_reg_if.irq                         rif,
  input  wire logic [DQ_NCH-1:0][31:0]  last_i,
  output logic                          irq_o
);
  typedef struct packed {
    logic [DQ_NCH-1:0][31:0] comp;
    logic [DQ_NCH-1:0]       en;
    logic                    irq;
  } dq_irq_t;

  dq_irq_t           q;
  dq_irq_t           n;
  logic [DQ_NCH-1:0] raw;
  logic [3:0]        idx;
  logic [1:0]        rgn;

  assign idx = rif.addr[DQ_IDX_MSB:DQ_IDX_LSB];
  assign rgn = rif.addr[DQ_RGN_MSB:DQ_RGN_LSB];

  for (genvar g = 0; g < DQ_NCH; g++) begin : g_raw
    assign raw[g] = q.comp[g] != last_i[g];
  end

  always_comb begin
    n = q;
    if (rif.wr) begin
      if (rgn == DQ_RGN_COMP) begin
        n.comp[idx] = rif.wdata;
      end
      // per channel enable set and clear
      case (rif.addr)
        DQ_TX_EN_SET: n.en[DQ_NDIR-1:0] = q.en[DQ_NDIR-1:0] | rif.wdata[DQ_NDIR-1:0];
        DQ_TX_EN_CLR: n.en[DQ_NDIR-1:0] = q.en[DQ_NDIR-1:0] & ~rif.wdata[DQ_NDIR-1:0];
        DQ_RX_EN_SET: n.en[DQ_NCH-1:DQ_NDIR] = q.en[DQ_NCH-1:DQ_NDIR] | rif.wdata[DQ_NDIR-1:0];
        DQ_RX_EN_CLR: n.en[DQ_NCH-1:DQ_NDIR] = q.en[DQ_NCH-1:DQ_NDIR] & ~rif.wdata[DQ_NDIR-1:0];
        default: n.en = n.en;
      endcase
    end
    // only enabled channels reach the output
    n.irq = |(raw & q.en);
  end

  always_comb begin
    rif.irq_hit   = 1'b1;
    rif.irq_rdata = 32'h0;
    case (rif.addr)
      DQ_TX_EN_SET, DQ_TX_EN_CLR: rif.irq_rdata[DQ_NDIR-1:0] = q.en[DQ_NDIR-1:0];
      DQ_RX_EN_SET, DQ_RX_EN_CLR: rif.irq_rdata[DQ_NDIR-1:0] = q.en[DQ_NCH-1:DQ_NDIR];
      DQ_TX_RAW: rif.irq_rdata[DQ_NDIR-1:0] = raw[DQ_NDIR-1:0];
      DQ_RX_RAW: rif.irq_rdata[DQ_NDIR-1:0] = raw[DQ_NCH-1:DQ_NDIR];
      default: begin
        rif.irq_hit = rgn == DQ_RGN_COMP;
        rif.irq_rdata = (rgn == DQ_RGN_COMP) ? last_i[idx] : 32'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      q    <= '0;
      q.en <= DQ_EN_RST;
    end else begin
      q <= n;
    end
  end

  assign irq_o = q.irq;
endmodule

// *** dv/dq_engine_properties.sv ***
`timescale 1ns/10ps
module dq_engine_properties import dq_pkg::*; (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic        mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic        job_valid_o,
  input wire logic        job_tx_o,
  input wire logic        job_first_o,
  input wire logic        job_last_o,
  input wire logic [15:0] job_pkt_len_o,
  input wire logic [31:0] job_addr_o,
  input wire logic [15:0] job_len_o,
  input wire logic        job_done_i
);
  logic [31:0] cur, nxt, bufp, w2, w3, ack_a;
  logic        off_on;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================
  // Descriptor words as the engine saw them
  always_ff @(posedge sys_clk_i) begin
    if (mem_req_o && mem_ack_i && !mem_we_o) begin
      ack_a <= mem_addr_o;
      case (mem_addr_o[3:0])
        4'h0: begin
          cur <= mem_addr_o;
          nxt <= mem_rdata_i;
        end
        4'h4: bufp <= mem_rdata_i;
        4'h8: w2 <= mem_rdata_i;
        4'hc: w3 <= mem_rdata_i;
        default: ;
      endcase
    end
  end
  // Offset counts only on a transmit first fragment
  assign off_on = job_tx_o && job_first_o;

  // ==========================================
  // Properties
  sequence s_rd_ack;
    mem_req_o && mem_ack_i && !mem_we_o && mem_addr_o[3:0] != 4'hc;
  endsequence
  sequence s_next_rd;
    mem_req_o && !mem_we_o && mem_addr_o == ack_a + 32'h4;
  endsequence
  property p_apb_wait;
    psel_i && $rose(penable_i) |-> !pready_o ##1 pready_o ##1 !pready_o;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb wait state");
  property p_req_hold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("mem request dropped");
  property p_word_seq;
    s_rd_ack |=> ##[0:3] s_next_rd;
  endproperty
  a_word_seq: assert property (p_word_seq)
    else $error("descriptor word order");
  property p_wr_word3;
    mem_req_o && mem_we_o |-> mem_addr_o[3:0] == 4'hc;
  endproperty
  a_wr_word3: assert property (p_wr_word3)
    else $error("write outside flag word");
  property p_end_flag;
    mem_req_o && mem_we_o && mem_addr_o == cur + 32'hc |->
      mem_wdata_o[DQ_F_HALT] == (nxt == 32'h0);
  endproperty
  a_end_flag: assert property (p_end_flag)
    else $error("list end flag");
  property p_hold_clr;
    mem_req_o && mem_we_o && mem_wdata_o[DQ_F_FIRST] |-> !mem_wdata_o[DQ_F_HOLD];
  endproperty
  a_hold_clr: assert property (p_hold_clr)
    else $error("hold flag kept");
  property p_job_fields;
    job_valid_o |-> job_len_o == w2[15:0] &&
      job_addr_o == bufp + (off_on ? {16'h0, w2[31:16]} : 32'h0);
  endproperty
  a_job_fields: assert property (p_job_fields)
    else $error("job fields");
  property p_job_hold;
    job_valid_o && !job_done_i |=> job_valid_o && $stable(job_addr_o);
  endproperty
  a_job_hold: assert property (p_job_hold)
    else $error("job dropped");
  property p_job_flags;
    job_valid_o |-> job_first_o == w3[DQ_F_FIRST] && job_last_o == w3[DQ_F_LAST] &&
      job_pkt_len_o == (off_on ? w3[15:0] : 16'h0);
  endproperty
  a_job_flags: assert property (p_job_flags)
    else $error("job flags");
endmodule

bind dq_engine dq_engine_properties u_props (.sys_clk_i, .rst_i, .psel_i, .penable_i,
  .pready_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i,
  .job_valid_o, .job_tx_o, .job_first_o, .job_last_o, .job_pkt_len_o, .job_addr_o,
  .job_len_o, .job_done_i);

// *** dv/dq_mem_model.sv ***
`timescale 1ns/10ps
module dq_mem_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [31:0] mem_wdata_i,
  output logic             mem_ack_o,
  output logic      [31:0] mem_rdata_o,
  input  wire logic        job_valid_i,
  input  wire logic [15:0] job_len_i,
  output logic             job_done_o,
  output logic      [15:0] job_moved_o
);
  logic [31:0] mem [0:1023];
  logic [15:0] moved;
  int          lat = 0;
  int          cnt;

  // ==========================================
  // Memory, wait states set by the bench
  // one word each
  always @(posedge sys_clk_i) begin
    mem_ack_o <= 1'b0;
    if (rst_i) begin
      cnt <= 0;
    end else if (mem_req_i && !mem_ack_o) begin
      if (cnt >= lat) begin
        mem_ack_o <= 1'b1;
        cnt <= 0;
        if (mem_we_i) begin
          mem[mem_addr_i[11:2]] <= mem_wdata_i;
        end
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
  // Inverted outside the ack so stale data cannot match
  assign mem_rdata_o = mem_ack_o ? mem[mem_addr_i[11:2]] : ~mem[mem_addr_i[11:2]];

  // ==========================================
  // Port side
  // whole buffer moved
  always @(posedge sys_clk_i) begin
    job_done_o <= !rst_i && job_valid_i && !job_done_o;
    moved <= job_len_i;
  end
  assign job_moved_o = job_done_o ? moved : ~moved;
endmodule

// *** dv/dq_engine_bench.sv ***
`timescale 1ns/10ps
module dq_engine_bench import dq_pkg::*;;
  logic             sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [DQ_AW-1:0] paddr_i;
  logic [31:0]      pwdata_i, prdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, job_addr_o, r;
  logic             mem_req_o, mem_we_o, mem_ack_i, irq_o, e;
  logic             job_valid_o, job_tx_o, job_first_o, job_last_o, job_done_i;
  logic [2:0]       job_chan_o;
  logic [15:0]      job_len_o, job_pkt_len_o, job_moved_i;
  logic [3:0]       jc;
  int               failures, checks, i;

  dq_engine DUT (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
    .mem_ack_i, .mem_rdata_i, .job_valid_o, .job_tx_o, .job_chan_o, .job_first_o,
    .job_last_o, .job_addr_o, .job_len_o, .job_pkt_len_o, .job_done_i, .job_moved_i, .irq_o);
  dq_mem_model u_mem (.sys_clk_i, .rst_i, .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i), .job_valid_i(job_valid_o), .job_len_i(job_len_o),
    .job_done_o(job_done_i), .job_moved_o(job_moved_i));

  // Direction and channel of the latest job offered
  always @(posedge sys_clk_i) begin
    if (job_valid_o) jc <= {job_tx_o, job_chan_o};
  end

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================
  // Tasks
  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    checks++;
    if (s !== x) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) begin
      failures++;
      $display("[ERR] pready expected 1 seen %b", pready_o);
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, r);
  endtask
  // Bounded wait: a late answer still shows up as a mismatch
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((r & m) !== v && n < 200);
    chk("poll", v, r & m);
  endtask
  task automatic mchk(input string n, input logic [31:0] a, input logic [31:0] x);
    int k;
    k = 0;
    while (u_mem.mem[a[11:2]] !== x && k < 100) begin
      @(posedge sys_clk_i);
      k++;
    end
    chk(n, x, u_mem.mem[a[11:2]]);
  endtask
  task automatic desc(input logic [31:0] a, nx, bp, w2, w3);
    u_mem.mem[a[11:2]] = nx;
    u_mem.mem[a[11:2] + 10'h1] = bp;
    u_mem.mem[a[11:2] + 10'h2] = w2;
    u_mem.mem[a[11:2] + 10'h3] = w3;
  endtask

  initial begin
    #200us;
    failures++;
    stop_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    failures = 0;
    checks = 0;
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h0;
    pwdata_i = 32'h0;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 16; i++) apb(1'b1, 8'(i * 4), 32'h0);
    for (i = 0; i < 38; i++) rchk("reset", 8'(i * 4), 32'h0);
    apb(1'b0, 8'h98, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    // Single packet with offset on transmit channel 2
    desc(32'h100, 32'h0, 32'h1000, 32'h0004_003c, 32'he000_003c);
    apb(1'b1, DQ_TX_EN_SET, 32'h4);
    rchk("tx enable", DQ_TX_EN_SET, 32'h4);
    apb(1'b1, 8'h08, 32'h100);
    poll(DQ_TX_RAW, 32'h4, 32'h4);
    mchk("tx flags", 32'h10c, 32'hd000_003c);
    rchk("tx raw", DQ_TX_RAW, 32'h4);
    rchk("tx last ptr", 8'h48, 32'h100);
    chk("irq on", 32'h1, {31'h0, irq_o});
    rchk("tx head", 8'h08, 32'h0);
    chk("tx chan", 32'ha, {28'h0, jc});
    apb(1'b1, 8'h48, 32'h104);
    rchk("wrong ack", DQ_TX_RAW, 32'h4);
    apb(1'b1, 8'h48, 32'h100);
    rchk("acked", DQ_TX_RAW, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq_o});
    apb(1'b1, DQ_TX_EN_CLR, 32'h4);
    rchk("tx enable clr", DQ_TX_EN_SET, 32'h0);
    // Two fragments on receive channel 1, interrupt left disabled
    desc(32'h200, 32'h210, 32'h2000, 32'h0000_0064, 32'ha000_0000);
    desc(32'h210, 32'h0, 32'h3000, 32'h0000_0032, 32'h4000_0000);
    apb(1'b1, 8'h24, 32'h200);
    poll(DQ_RX_RAW, 32'h2, 32'h2);
    mchk("rx first", 32'h20c, 32'h8000_0096);
    mchk("rx last", 32'h21c, 32'h5000_0000);
    rchk("rx raw", DQ_RX_RAW, 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    rchk("rx last ptr", 8'h64, 32'h210);
    chk("rx chan", 32'h1, {28'h0, jc});
    apb(1'b1, DQ_RX_EN_SET, 32'h2);
    rchk("rx enable", DQ_RX_EN_CLR, 32'h2);
    chk("irq rx on", 32'h1, {31'h0, irq_o});
    apb(1'b1, DQ_RX_EN_CLR, 32'h2);
    rchk("rx enable clr", DQ_RX_EN_SET, 32'h0);
    chk("irq rx off", 32'h0, {31'h0, irq_o});
    // Packet not handed over stays untouched
    desc(32'h280, 32'h0, 32'h4000, 32'h0000_000a, 32'hc000_000a);
    apb(1'b1, 8'h00, 32'h280);
    poll(8'h00, 32'hffff_ffff, 32'h0);
    mchk("not handed", 32'h28c, 32'hc000_000a);
    rchk("not handed ptr", 8'h40, 32'h0);
    // Two-packet list with slow memory; second head write must be ignored
    u_mem.lat = 3;
    desc(32'h300, 32'h310, 32'h5000, 32'h0002_0014, 32'he000_0014);
    desc(32'h310, 32'h0, 32'h6000, 32'h0000_001e, 32'he000_001e);
    desc(32'h400, 32'h0, 32'h7000, 32'h0000_0008, 32'he000_0008);
    apb(1'b1, 8'h0c, 32'h300);
    apb(1'b1, 8'h0c, 32'h400);
    rchk("head kept", 8'h0c, 32'h300);
    poll(8'h4c, 32'hffff_ffff, 32'h310);
    mchk("list a", 32'h30c, 32'hc000_0014);
    mchk("list b", 32'h31c, 32'hd000_001e);
    mchk("ignored head", 32'h40c, 32'he000_0008);
    rchk("list raw", DQ_TX_RAW, 32'h8);
    // Late patch is missed; software restarts the halted channel
    rchk("halted head", 8'h0c, 32'h0);
    u_mem.mem[10'h0c4] = 32'h400;
    apb(1'b1, 8'h0c, 32'h400);
    poll(8'h4c, 32'hffff_ffff, 32'h400);
    mchk("restart", 32'h40c, 32'hd000_0008);
    stop_test();
  end
endmodule
